// ### shared/sbr_pkg.sv
/*
 * sbr_pkg: constants and types for the snoop-result block.
 * Assumes a single bus clock; bus inputs are active high and already decoded.
 */
package sbr_pkg;

	localparam int ADDR_W = 32;
	localparam int CMD_W  = 4;
	localparam int CNT_W  = 4;

	// bus command for memory write and invalidate
	localparam logic [CMD_W-1:0] CMD_MWI = 4'hf;

	// handling of memory write and invalidate
	localparam logic [1:0] MWI_CLEAN = 2'h0;
	localparam logic [1:0] MWI_HITM  = 2'h1;
	localparam logic [1:0] MWI_WAIT  = 2'h2;

	// fixed wait for target-ready before an invalidate result, in clocks
	localparam logic [CNT_W-1:0] MWI_WAIT_CYC = 4'h4;
	localparam logic [CNT_W-1:0] CNT_ONE      = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO     = 4'h0;

	// pending address count
	localparam logic [1:0] QCNT_0 = 2'h0;
	localparam logic [1:0] QCNT_1 = 2'h1;
	localparam logic [1:0] QCNT_2 = 2'h2;

	// snoop result pin levels: done high, modified-hit low-active
	localparam logic DONE_ON  = 1'h1;
	localparam logic DONE_OFF = 1'h0;
	localparam logic MOD_ON_N  = 1'h0;
	localparam logic MOD_OFF_N = 1'h1;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_LOOK,
		ST_MWI_WAIT,
		ST_CLEAN,
		ST_HITM,
		ST_WB_CLEAN
	} sbr_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [CMD_W-1:0]  cmd;
		logic              own;
		logic              own_clean;
	} sbr_entry_t;

endpackage : sbr_pkg

// ### design/sbr_addr_queue.sv
/*
 * sbr_addr_queue: two-entry latch of bus addresses awaiting snoop.
 * Assumes push, pop and drop are single-cycle strobes from the controller.
 */
`timescale 1ns/1ns
module sbr_addr_queue
	import sbr_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	// control
	input  wire logic              push_i,
	input  wire sbr_pkg::sbr_entry_t entry_i,
	input  wire logic              pop_i,
	input  wire logic              drop2_i,
	// status
	output logic [1:0]             count_o,
	output sbr_pkg::sbr_entry_t    head_o
);
	import sbr_pkg::*;

	typedef struct packed {
		sbr_entry_t e0;
		sbr_entry_t e1;
		logic [1:0] cnt;
	} sbr_q_t;

	sbr_q_t q_q;
	sbr_q_t q_d;

	always_comb begin
		q_d = q_q;
		// discard the second address, its transfer already ended
		if (drop2_i && q_d.cnt == QCNT_2) begin
			q_d.cnt = QCNT_1;
		end
		if (pop_i && q_d.cnt != QCNT_0) begin
			q_d.e0  = q_d.e1;
			q_d.cnt = q_d.cnt - QCNT_1;
		end
		// at most two addresses held
		if (push_i && q_d.cnt != QCNT_2) begin // RULE_02
			if (q_d.cnt == QCNT_0) begin
				q_d.e0 = entry_i;
			end else begin
				q_d.e1 = entry_i;
			end
			q_d.cnt = q_d.cnt + QCNT_1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q_q <= '0;
		end else begin
			q_q <= q_d;
		end
	end

	assign count_o = q_q.cnt;
	assign head_o  = q_q.e0;

endmodule : sbr_addr_queue

// ### design/sbr_snoop_ctrl.sv
/*
 * sbr_snoop_ctrl: cache-side snoop-result generator for a shared bus.
 * Assumes bus inputs are decoded active-high strobes synchronous to clk_sys_i,
 * a tag lookup engine that answers each request with one done pulse, and a
 * master engine that runs the full-line writeback when asked.
 */
`timescale 1ns/1ns

// Function
// [RULE_01] standby is done low; clean is 11; modified hit is done with low hit
// [RULE_02] hold two snoop addresses; second snoop starts right after first
// [RULE_03] drive standby while snooping, then clean when snoop finishes clean
// [RULE_04] after clean return to standby when no second address waits
// [RULE_05] second address from another master: standby after clean
// [RULE_06] own second writeback or known clean: clean may continue
// [RULE_07] hold modified hit until the dirty line is written back
// [RULE_08] clean in writeback address phase, then standby
// [RULE_09] cacheable target waits with target-ready off until snoop done
// [RULE_10] once modified-hit asserts, it stays until done also asserts
// [RULE_11] cacheable target retries a transaction that sees modified hit
// [RULE_12] memory controller floats data on reads when modified hit shown
// [RULE_13] while modified hit shows, cacheable transactions are retried
// [RULE_14] writeback moves the whole line in one transaction
// [RULE_15] memory controller stalls a writeback it cannot take yet
// [RULE_16] a locked target still accepts snoop writebacks
// [RULE_17] both sides may insert wait states during the writeback
// [RULE_18] write-and-invalidate may report clean on a dirty hit, invalidating it
// [RULE_19] done only asserts when ready for the next snoop address
// [RULE_20] write-and-invalidate may be treated as a normal modified hit
// [RULE_21] a wait for target-ready before the result has fixed length
// [RULE_22] target-ready seen during that wait: discard line, report clean
// [RULE_23] result refers to first address; next done belongs to second
// [RULE_24] second transaction ending during first snoop is not snooped
// [RULE_25] writeback order is independent of the triggering transaction
// [RULE_26] snoop signals sampled and state updated on the clock edge
module sbr_snoop_ctrl
	import sbr_pkg::*;
(
	// clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      rst_i,
	// bus observation
	input  wire logic                      addr_start_i,
	input  wire logic [sbr_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [sbr_pkg::CMD_W-1:0]  cmd_i,
	input  wire logic                      own_master_i,
	input  wire logic                      own_clean_i,
	input  wire logic                      trdy_i,
	input  wire logic                      stop_i,
	// configuration
	input  wire logic [1:0]                mwi_mode_i,
	// tag lookup engine
	output logic                           lookup_req_o,
	output logic [sbr_pkg::ADDR_W-1:0]     lookup_addr_o,
	input  wire logic                      lookup_done_i,
	input  wire logic                      lookup_hit_mod_i,
	// writeback and invalidate
	output logic                           wb_req_o,
	output logic [sbr_pkg::ADDR_W-1:0]     wb_addr_o,
	input  wire logic                      wb_addr_phase_i,
	output logic                           inval_o,
	output logic [sbr_pkg::ADDR_W-1:0]     inval_addr_o,
	// snoop result pins
	output logic                           sdone_o,
	output logic                           sbo_n_o,
	// status
	output logic [1:0]                     pend_cnt_o
);
	import sbr_pkg::*;

	typedef struct packed {
		sbr_state_t        st;
		logic              sdone;
		logic              sbo_n;
		logic              lk_req;
		logic [ADDR_W-1:0] lk_addr;
		logic              lk_mwi;
		logic              hit_mod;
		logic [CNT_W-1:0]  cnt;
		logic              trdy_seen;
		logic              wb_req;
		logic [ADDR_W-1:0] wb_addr;
		logic              inval;
	} sbr_ctl_t;

	sbr_ctl_t   c_q;
	sbr_ctl_t   c_d;
	logic       push;
	logic       pop;
	logic       drop2;
	logic [1:0] qcnt;
	sbr_entry_t head;
	sbr_entry_t new_ent;

	// address latch
	sbr_addr_queue u_queue (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.push_i    (push),
		.entry_i   (new_ent),
		.pop_i     (pop),
		.drop2_i   (drop2),
		.count_o   (qcnt),
		.head_o    (head)
	);

	always_comb begin
		new_ent.addr      = addr_i;
		new_ent.cmd       = cmd_i;
		new_ent.own       = own_master_i;
		new_ent.own_clean = own_clean_i;
	end

	// no address latched while modified hit stands; targets retry those
	assign push = addr_start_i && c_q.st != ST_HITM; // RULE_13

	// second transfer ended while first still snooping: not snooped
	assign drop2 = (trdy_i || stop_i) && qcnt == QCNT_2; // RULE_24

	always_comb begin
		c_d        = c_q;
		pop        = 1'b0;
		c_d.lk_req = 1'b0;
		c_d.inval  = 1'b0;
		case (c_q.st)
			ST_STANDBY: begin
				c_d.sdone = DONE_OFF;
				c_d.sbo_n = MOD_OFF_N;
				// start the next snoop straight away
				if (qcnt != QCNT_0) begin // RULE_02
					c_d.lk_req  = 1'b1;
					c_d.lk_addr = head.addr;
					c_d.lk_mwi  = head.cmd == CMD_MWI;
					c_d.st      = ST_LOOK;
				end
			end
			ST_LOOK: begin
				// standby stays on the pins while the lookup runs
				if (lookup_done_i) begin // RULE_03
					c_d.hit_mod = lookup_hit_mod_i;
					if (c_q.lk_mwi && mwi_mode_i == MWI_WAIT) begin
						c_d.cnt       = MWI_WAIT_CYC - CNT_ONE; // RULE_21
						c_d.trdy_seen = trdy_i;
						c_d.st        = ST_MWI_WAIT;
					end else if (c_q.lk_mwi && mwi_mode_i == MWI_CLEAN) begin
						// dirty line dropped, every byte gets overwritten
						c_d.inval = lookup_hit_mod_i; // RULE_18
						c_d.sdone = DONE_ON;
						c_d.sbo_n = MOD_OFF_N;
						pop       = 1'b1; // RULE_23
						c_d.st    = ST_CLEAN;
					end else if (lookup_hit_mod_i) begin
						// also write-and-invalidate in normal handling
						c_d.sdone   = DONE_ON; // RULE_20
						c_d.sbo_n   = MOD_ON_N;
						c_d.wb_req  = 1'b1; // RULE_14
						c_d.wb_addr = c_q.lk_addr;
						pop         = 1'b1;
						c_d.st      = ST_HITM;
					end else begin
						c_d.sdone = DONE_ON; // RULE_03
						c_d.sbo_n = MOD_OFF_N;
						pop       = 1'b1;
						c_d.st    = ST_CLEAN;
					end
				end
			end
			ST_MWI_WAIT: begin
				c_d.trdy_seen = c_q.trdy_seen || trdy_i;
				c_d.cnt       = c_q.cnt - CNT_ONE;
				// result only after the full fixed wait
				if (c_q.cnt == CNT_ZERO) begin // RULE_21
					pop       = 1'b1;
					c_d.sdone = DONE_ON;
					if (c_q.hit_mod && !(c_q.trdy_seen || trdy_i)) begin
						c_d.sbo_n   = MOD_ON_N;
						c_d.wb_req  = 1'b1;
						c_d.wb_addr = c_q.lk_addr;
						c_d.st      = ST_HITM;
					end else begin
						c_d.inval = c_q.hit_mod; // RULE_22
						c_d.sbo_n = MOD_OFF_N;
						c_d.st    = ST_CLEAN;
					end
				end
			end
			ST_CLEAN: begin
				// own second address that is also known clean: clean again
				if (qcnt != QCNT_0 && head.own && head.own_clean && !drop2) begin // RULE_06
					pop       = 1'b1; // RULE_23
					c_d.sdone = DONE_ON;
					c_d.sbo_n = MOD_OFF_N;
				end else begin
					// standby: idle, or second snoop in progress
					c_d.sdone = DONE_OFF; // RULE_04 RULE_05
					c_d.sbo_n = MOD_OFF_N;
					c_d.st    = ST_STANDBY;
				end
			end
			ST_HITM: begin
				// modified hit held with done until the writeback starts
				c_d.sdone = DONE_ON; // RULE_10
				c_d.sbo_n = MOD_ON_N; // RULE_07
				if (wb_addr_phase_i) begin // RULE_25 RULE_17
					c_d.sbo_n  = MOD_OFF_N; // RULE_08
					c_d.wb_req = 1'b0;
					c_d.st     = ST_WB_CLEAN;
				end
			end
			ST_WB_CLEAN: begin
				// back to standby, ready for a new address
				c_d.sdone = DONE_OFF; // RULE_08 RULE_19
				c_d.sbo_n = MOD_OFF_N;
				c_d.st    = ST_STANDBY;
			end
			default: begin
				c_d.sdone  = DONE_OFF;
				c_d.sbo_n  = MOD_OFF_N;
				c_d.wb_req = 1'b0;
				c_d.st     = ST_STANDBY;
			end
		endcase
	end

	// all state moves on the rising edge
	always_ff @(posedge clk_sys_i) begin // RULE_26
		if (rst_i) begin
			c_q       <= '0;
			c_q.st    <= ST_STANDBY;
			c_q.sdone <= DONE_OFF;
			c_q.sbo_n <= MOD_OFF_N;
		end else begin
			c_q <= c_d;
		end
	end

	// pin encoding: 0x standby, 11 clean, 10 modified hit
	assign sdone_o       = c_q.sdone; // RULE_01
	assign sbo_n_o       = c_q.sbo_n; // RULE_01
	assign lookup_req_o  = c_q.lk_req;
	assign lookup_addr_o = c_q.lk_addr;
	assign wb_req_o      = c_q.wb_req;
	assign wb_addr_o     = c_q.wb_addr;
	assign inval_o       = c_q.inval;
	assign inval_addr_o  = c_q.lk_addr;
	assign pend_cnt_o    = qcnt;

endmodule : sbr_snoop_ctrl

// ### testbench/sbr_snoop_ctrl_props.sv
/* sbr_props: snoop result checks on the controller ports.
 * assumes it is bound to sbr_snoop_ctrl, one clock domain. */
`timescale 1ns/1ns
module sbr_props
	import sbr_pkg::*;
(
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       addr_start_i,
	input wire logic       trdy_i,
	input wire logic       stop_i,
	input wire logic [1:0] mwi_mode_i,
	input wire logic       lookup_done_i,
	input wire logic       lookup_hit_mod_i,
	input wire logic       wb_addr_phase_i,
	input wire logic       lookup_req_o,
	input wire logic       wb_req_o,
	input wire logic       inval_o,
	input wire logic       sdone_o,
	input wire logic       sbo_n_o,
	input wire logic [1:0] pend_cnt_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_reset_idle: assert property ($fell(rst_i) |->
		!sdone_o && sbo_n_o && pend_cnt_o == 2'h0) else $error("not idle after reset");
	a_pend_max: assert property (pend_cnt_o != 2'h3)
		else $error("more than two addresses");
	a_clean_after: assert property (lookup_done_i && !lookup_hit_mod_i &&
		mwi_mode_i != MWI_WAIT |=> sdone_o && sbo_n_o) else $error("no clean result");
	a_clean_standby: assert property (sdone_o && sbo_n_o &&
		pend_cnt_o == 2'h0 |=> !sdone_o) else $error("no standby after clean");
	a_hitm_result: assert property (lookup_done_i && lookup_hit_mod_i &&
		mwi_mode_i == MWI_HITM |=> sdone_o && !sbo_n_o && wb_req_o) else $error("no hitm");
	a_hitm_hold: assert property (!sbo_n_o && !wb_addr_phase_i |=>
		!sbo_n_o && $stable(wb_req_o)) else $error("hitm dropped early");
	a_hit_done: assert property (!sbo_n_o |-> sdone_o)
		else $error("modified hit without done");
	a_wb_release: assert property (!sbo_n_o && wb_addr_phase_i |=>
		sdone_o && sbo_n_o && !wb_req_o ##1 !sdone_o) else $error("bad writeback exit");
	a_look_standby: assert property (lookup_req_o |-> !sdone_o ##1
		!lookup_req_o && !sdone_o) else $error("result during lookup request");
	a_inval_clean: assert property (inval_o |-> sdone_o && sbo_n_o)
		else $error("invalidate without clean");
	a_second_drop: assert property (pend_cnt_o == 2'h2 && (trdy_i || stop_i) &&
		!addr_start_i |=> pend_cnt_o != 2'h2) else $error("second address kept");
endmodule : sbr_props

bind sbr_snoop_ctrl sbr_props sbr_props_i (.clk_sys_i, .rst_i, .addr_start_i, .trdy_i,
	.stop_i, .mwi_mode_i, .lookup_done_i, .lookup_hit_mod_i, .wb_addr_phase_i, .lookup_req_o,
	.wb_req_o, .inval_o, .sdone_o, .sbo_n_o, .pend_cnt_o);

// ### testbench/sbr_lookup_model.sv
/* sbr_lookup_model: tag lookup engine answering each request.
 * assumes one request outstanding; latency and hit set by the bench. */
`timescale 1ns/1ns
module sbr_lookup_model (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// request
	input  wire logic       req_i,
	input  wire logic       hit_sel_i,
	input  wire logic [3:0] lat_i,
	// answer
	output logic            done_o,
	output logic            hit_o
);
	logic [3:0] cnt_q;
	logic       tog_q;
	// hit only valid with done, else toggles
	assign hit_o = done_o ? hit_sel_i : tog_q;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_q  <= 4'h0;
			done_o <= 1'b0;
			tog_q  <= 1'b0;
		end else begin
			tog_q  <= ~tog_q;
			done_o <= (cnt_q == 4'h1);
			if (req_i)
				cnt_q <= lat_i;
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule : sbr_lookup_model

// ### testbench/tb_top.sv
/* tb_top: self-checking bench for the snoop result controller.
 * assumes the lookup model as far side; writeback phase driven here. */
`timescale 1ns/1ns
module tb_top;
	import sbr_pkg::*;
	logic              clk_sys_i, rst_i, addr_start_i, own_master_i, own_clean_i;
	logic              trdy_i, stop_i, lookup_req_o, lookup_done_i, lookup_hit_mod_i;
	logic              wb_req_o, wb_addr_phase_i, inval_o, sdone_o, sbo_n_o, hit_sel;
	logic [ADDR_W-1:0] addr_i, lookup_addr_o, wb_addr_o, inval_addr_o;
	logic [CMD_W-1:0]  cmd_i;
	logic [1:0]        mwi_mode_i, pend_cnt_o;
	logic [3:0]        lat;
	int                err_total, compares, n;

	sbr_snoop_ctrl sbr_snoop_ctrl_i (.clk_sys_i, .rst_i, .addr_start_i, .addr_i, .cmd_i,
		.own_master_i, .own_clean_i, .trdy_i, .stop_i, .mwi_mode_i, .lookup_req_o,
		.lookup_addr_o, .lookup_done_i, .lookup_hit_mod_i, .wb_req_o, .wb_addr_o,
		.wb_addr_phase_i, .inval_o, .inval_addr_o, .sdone_o, .sbo_n_o, .pend_cnt_o);
	sbr_lookup_model sbr_lookup_model_i (.clk_sys_i, .rst_i, .req_i(lookup_req_o),
		.hit_sel_i(hit_sel), .lat_i(lat), .done_o(lookup_done_i), .hit_o(lookup_hit_mod_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	task automatic tick;
		@(posedge clk_sys_i);
		#10;
	endtask : tick

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (e !== s) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	function automatic logic exp_hitm(logic [3:0] c, logic [1:0] m, logic h, logic t);
		if (!h || (c == CMD_MWI && m == MWI_CLEAN)) return 1'b0;
		if (c == CMD_MWI && m == MWI_WAIT) return !t;
		return 1'b1;
	endfunction : exp_hitm

	task automatic wait_done;
		n = 0;
		while (sdone_o !== 1'b1 && n < 60) begin
			tick;
			n++;
		end
	endtask : wait_done

	task automatic start(input logic [31:0] a, input logic own);
		addr_i = a;
		own_master_i = own;
		own_clean_i = own;
		addr_start_i = 1'b1;
		tick;
		addr_start_i = 1'b0;
		own_master_i = 1'b0;
		own_clean_i = 1'b0;
	endtask : start

	task automatic run_one(input logic [31:0] a, input logic [3:0] c, input logic [1:0] m,
		input logic h, input logic t);
		logic e;
		e = exp_hitm(c, m, h, t);
		mwi_mode_i = m;
		hit_sel = h;
		cmd_i = c;
		start(a, 1'b0);
		trdy_i = t;
		wait_done;
		trdy_i = 1'b0;
		chk("latency", 3 + lat + ((c == CMD_MWI && m == MWI_WAIT) ? MWI_WAIT_CYC : 4'h0), n);
		chk("lookup_addr", a, lookup_addr_o);
		chk("sbo_n", !e, sbo_n_o);
		chk("inval", h && !e, inval_o);
		if (h && !e)
			chk("inval_addr", a, inval_addr_o);
		chk("wb_req", e, wb_req_o);
		if (e) begin
			chk("wb_addr", a, wb_addr_o);
			// memory side retries the hit transfer and a new cacheable one
			stop_i = 1'b1;
			start(~a, 1'b0);
			stop_i = 1'b0;
			chk("pend_hitm", 0, pend_cnt_o);
			repeat ($urandom_range(4)) begin
				tick;
				chk("hitm_hold", 0, sbo_n_o);
			end
			wb_addr_phase_i = 1'b1;
			tick;
			wb_addr_phase_i = 1'b0;
			chk("wb_clean", 1, sdone_o & sbo_n_o);
			chk("wb_req_off", 0, wb_req_o);
			tick;
			chk("wb_standby", 0, sdone_o);
			// writeback data: memory stalls up to 3 clocks, then takes the whole line
			repeat ($urandom_range(3)) tick;
			trdy_i = 1'b1;
		end
		tick;
		chk("standby", 0, sdone_o);
		trdy_i = 1'b0;
	endtask : run_one

	task automatic run_two(input logic own, input logic drop);
		hit_sel = 1'b0;
		mwi_mode_i = MWI_HITM;
		cmd_i = 4'h6;
		start(32'h100, 1'b0);
		start(32'h200, own);
		chk("pend_two", 2, pend_cnt_o);
		stop_i = drop;
		tick;
		stop_i = 1'b0;
		chk("pend_drop", drop ? 1 : 2, pend_cnt_o);
		wait_done;
		chk("first", 32'h100, lookup_addr_o);
		tick;
		chk("second_clean", own, sdone_o);
		if (!own && !drop) begin
			wait_done;
			chk("second_addr", 32'h200, lookup_addr_o);
			tick;
		end else if (own)
			tick;
		chk("idle", 0, {sdone_o, pend_cnt_o});
	endtask : run_two

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	initial begin
		{addr_start_i, own_master_i, own_clean_i, trdy_i, stop_i} = 5'h00;
		{wb_addr_phase_i, hit_sel, mwi_mode_i, cmd_i, addr_i} = '0;
		lat = 4'h1;
		err_total = 0;
		compares = 0;
		rst_i = 1'b1;
		void'($urandom(32358));
		repeat (10) @(posedge clk_sys_i);
		#10;
		rst_i = 1'b0;
		chk("reset_sbo", 1, sbo_n_o);
		for (int k = 0; k < 12; k++)
			run_one(32'h40 * k, CMD_MWI, 2'(k / 4), k[0], k[1]);
		$display("test mwi modes done");
		repeat (40) begin
			lat = 4'($urandom_range(1, 6));
			run_one($urandom, 4'($urandom_range(15)), 2'($urandom_range(1)),
				1'($urandom_range(1)), 1'b0);
		end
		$display("test random snoops done");
		lat = 4'h3;
		run_two(1'b0, 1'b0);
		run_two(1'b1, 1'b0);
		lat = 4'h8;
		run_two(1'b0, 1'b1);
		$display("test two addresses done");
		print_verdict;
	end

	initial begin
		#(100 * 5000);
		err_total++;
		print_verdict;
	end
endmodule : tb_top
